/* File: core/ups_status_indicator.sv */
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - green LED solid when battery above 85%, wiring fine, input adequate.
// - green LED slow blink while battery charges below 85%.
// - green LEDs fast blink while in battery mode.
// - ready indication held back at least 20s after power-up.
// - yellow solid on overload: above 20A battery mode, 25A supply mode.
// - yellow slow blink once a battery failed its quality test.
// - failed test darkens that battery's green LED, both without center tap.
// - yellow double flash for 15 minutes after output switched off.
// - yellow fast blink while inhibit disables buffering.
// - red solid on wiring, battery or fuse fault.
// - red single flash on input above 30V or under buffer voltage plus 1V.
// - red double flash on over-temperature; battery checks need a sensor.
// - size jumper gives two settings; absent jumper means small.
// - buffer event ends after selected limit; unlimited is default.
// - battery-mode voltage from four-position selector, default 22.5V.
// - first green LED for positive-side battery, second for negative side.
module ups_status_indicator
  import ups_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int READY_MS = READY_DELAY_S * MS_PER_S,
  parameter int HOLD_MS = EXPIRED_HOLD_MIN * S_PER_MIN * MS_PER_S,
  parameter int SLOW_MS = SLOW_PERIOD_MS,
  parameter int FAST_MS = FAST_PERIOD_MS,
  parameter int FRAME_MS = FLASH_FRAME_MS,
  parameter int ON_MS = FLASH_ON_MS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic [1:0] charged_85,
  input wire logic [1:0] charging,
  input wire logic battery_mode,
  input wire logic wiring_fault,
  input wire logic battery_fault,
  input wire logic fuse_fault,
  input wire logic input_low,
  input wire logic input_over_30v,
  input wire logic input_margin_low,
  input wire logic current_over_20a,
  input wire logic current_over_25a,
  input wire logic [1:0] test_fail_evt,
  input wire logic center_tap,
  input wire logic discharged_evt,
  input wire logic inhibit,
  input wire logic unit_over_70c,
  input wire logic batt_over_50c,
  input wire logic batt_under_m10c,
  input wire logic temp_sensor,
  input wire logic size_jumper,
  input wire logic [2:0] limiter_pos,
  input wire logic [1:0] voltage_pos,
  output logic [1:0] led_green,
  output logic led_yellow,
  output logic led_red,
  output logic buffer_stop,
  output logic size_large,
  output logic [15:0] buffer_mv,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic on_window(input logic [PH_W-1:0] ph, input int period);
    // first half of each period is lit
    on_window = (int'(ph) % period) < (period / 2);
  endfunction

  function automatic logic [MS_W-1:0] limit_ms(input logic [2:0] pos);
    case (pos)
      LIM_POS_A: limit_ms = MS_W'(LIM_A_S * MS_PER_S);
      LIM_POS_B: limit_ms = MS_W'(LIM_B_S * MS_PER_S);
      LIM_POS_C: limit_ms = MS_W'(LIM_C_S * MS_PER_S);
      LIM_POS_D: limit_ms = MS_W'(LIM_D_MIN * S_PER_MIN * MS_PER_S);
      LIM_POS_E: limit_ms = MS_W'(LIM_E_MIN * S_PER_MIN * MS_PER_S);
      default: limit_ms = '0;
    endcase
  endfunction

  logic [15:0] tick_cnt_reg;
  logic tick_reg;
  logic [PH_W-1:0] ph_reg;
  logic [MS_W-1:0] rdy_ms_reg;
  logic rdy_done_reg;
  logic [MS_W-1:0] buf_ms_reg;
  logic buffer_stop_reg;
  logic [MS_W-1:0] exp_ms_reg;
  logic expired_reg;
  logic [1:0] failed_reg;
  logic [1:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;
  logic wiring_any_reg;
  logic batt_mode_d_reg;
  logic [31:0] rd_data_reg;
  logic [1:0] led_green_reg;
  logic led_yellow_reg;
  logic led_red_reg;
  logic size_large_reg;
  logic [15:0] buffer_mv_reg;
  led_mode_type green_mode [2];
  led_mode_type yellow_mode;
  led_mode_type red_mode;
  logic slow_on, fast_on, single_on, double_on;
  logic wiring_any, limit_hit, off_evt, irq_any;
  logic [MS_W-1:0] lim;

  ////////////////////////////////////////////////////////////////////////////
  // millisecond tick and pattern phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (int'(tick_cnt_reg) == TICK_DIV - 1) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h1;
      tick_reg <= 1'b0;
    end
  end

  // one frame holds whole slow, fast and flash cycles
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ph_reg <= '0;
    end else if (tick_reg) begin
      ph_reg <= (int'(ph_reg) == FRAME_MS - 1) ? '0 : ph_reg + PH_W'(1);
    end
  end

  // pattern levels from the shared phase
  assign slow_on = on_window(ph_reg, SLOW_MS);
  assign fast_on = on_window(ph_reg, FAST_MS);
  assign single_on = int'(ph_reg) < ON_MS;
  assign double_on = single_on || (int'(ph_reg) >= 2 * ON_MS && int'(ph_reg) < 3 * ON_MS);

  ////////////////////////////////////////////////////////////////////////////
  // power-up ready hold-off, so a charged battery is shown as charging first
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdy_ms_reg <= '0;
      rdy_done_reg <= 1'b0;
    end else if (tick_reg && !rdy_done_reg) begin
      rdy_ms_reg <= rdy_ms_reg + MS_W'(1);
      rdy_done_reg <= int'(rdy_ms_reg) == READY_MS - 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer time limiter; position zero never ends the event
  assign lim = limit_ms(limiter_pos);
  assign limit_hit = battery_mode && tick_reg && !buffer_stop_reg && lim != '0
    && buf_ms_reg == lim - MS_W'(1);
  assign off_evt = limit_hit || discharged_evt;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      buf_ms_reg <= '0;
      buffer_stop_reg <= 1'b0;
    end else if (!battery_mode) begin
      buf_ms_reg <= '0;
      buffer_stop_reg <= 1'b0;
    end else if (limit_hit) begin
      buffer_stop_reg <= 1'b1;
    end else if (tick_reg && !buffer_stop_reg) begin
      buf_ms_reg <= buf_ms_reg + MS_W'(1);
    end
  end

  // expiry indication holds for the full interval, retriggered by a new event
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      exp_ms_reg <= '0;
      expired_reg <= 1'b0;
    end else if (off_evt) begin
      exp_ms_reg <= '0;
      expired_reg <= 1'b1;
    end else if (expired_reg && tick_reg) begin
      exp_ms_reg <= exp_ms_reg + MS_W'(1);
      expired_reg <= int'(exp_ms_reg) != HOLD_MS - 1;
    end
  end

  // a failed quality test stays until power is cycled
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      failed_reg <= '0;
    end else begin
      failed_reg <= failed_reg | test_fail_evt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern selection, faults ahead of information
  assign wiring_any = wiring_fault || battery_fault || fuse_fault;
  assign irq_any = |(irq_status_reg & irq_mask_reg);

  always_comb begin
    for (int b = 0; b < 2; b++) begin
      // index 0 is the battery at the positive pole
      if (failed_reg[b] || (failed_reg != 2'b00 && !center_tap)) begin
        green_mode[b] = LED_OFF;
      end else if (battery_mode) begin
        green_mode[b] = LED_FAST;
      end else if (charged_85[b] && !wiring_any && !input_low && rdy_done_reg) begin
        green_mode[b] = LED_SOLID;
      end else if (charging[b] || charged_85[b]) begin
        green_mode[b] = LED_SLOW;
      end else begin
        green_mode[b] = LED_OFF;
      end
    end
  end

  always_comb begin
    if (failed_reg != 2'b00) begin
      yellow_mode = LED_SLOW;
    end else if (battery_mode ? current_over_20a : current_over_25a) begin
      yellow_mode = LED_SOLID;
    end else if (expired_reg) begin
      yellow_mode = LED_DOUBLE;
    end else if (inhibit) begin
      yellow_mode = LED_FAST;
    end else begin
      yellow_mode = LED_OFF;
    end
  end

  always_comb begin
    if (wiring_any) begin
      red_mode = LED_SOLID;
    end else if (unit_over_70c || (temp_sensor && (batt_over_50c || (!size_jumper && batt_under_m10c)))) begin
      red_mode = LED_DOUBLE;
    end else if (input_over_30v || input_margin_low) begin
      red_mode = LED_SINGLE;
    end else begin
      red_mode = LED_OFF;
    end
  end

  function automatic logic show(input led_mode_type m, input logic [1:0] c,
                                input logic s, input logic f, input logic o, input logic d);
    if (c[CTRL_LAMP_TEST]) begin
      show = 1'b1;
    end else if (!c[CTRL_LED_EN]) begin
      show = 1'b0;
    end else begin
      case (m)
        LED_SOLID: show = 1'b1;
        LED_SLOW: show = s;
        LED_FAST: show = f;
        LED_SINGLE: show = o;
        LED_DOUBLE: show = d;
        default: show = 1'b0;
      endcase
    end
  endfunction

  // registered LED drive; software can blank them or force a lamp test
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      led_green_reg <= '0;
      led_yellow_reg <= 1'b0;
      led_red_reg <= 1'b0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        led_green_reg[b] <= show(green_mode[b], ctrl_reg, slow_on, fast_on, single_on, double_on);
      end
      led_yellow_reg <= show(yellow_mode, ctrl_reg, slow_on, fast_on, single_on, double_on);
      led_red_reg <= show(red_mode, ctrl_reg, slow_on, fast_on, single_on, double_on);
    end
  end

  // selector decode for the converter and charger
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      size_large_reg <= 1'b0;
      buffer_mv_reg <= VOLT_0_MV;
    end else begin
      size_large_reg <= size_jumper;
      case (voltage_pos)
        2'h1: buffer_mv_reg <= VOLT_1_MV;
        2'h2: buffer_mv_reg <= VOLT_2_MV;
        2'h3: buffer_mv_reg <= VOLT_3_MV;
        default: buffer_mv_reg <= VOLT_0_MV;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event edges for the interrupt status
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wiring_any_reg <= 1'b0;
      batt_mode_d_reg <= 1'b0;
    end else begin
      wiring_any_reg <= wiring_any;
      batt_mode_d_reg <= battery_mode;
    end
  end

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~((wr_en && addr == ADDR_IRQ_STATUS) ? wr_data[IRQ_W-1:0] : '0))
        | {battery_mode && !batt_mode_d_reg, wiring_any && !wiring_any_reg, off_evt, |test_fail_evt};
    end
  end

  // software-written control and mask
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_mask_reg <= MASK_RESET;
      ctrl_reg <= CTRL_RESET;
    end else if (wr_en) begin
      if (addr == ADDR_IRQ_MASK) begin
        irq_mask_reg <= wr_data[IRQ_W-1:0];
      end
      if (addr == ADDR_CTRL) begin
        ctrl_reg <= wr_data[1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_any;
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !rd_en) begin
      rd_data_reg <= '0;
    end else begin
      case (addr)
        ADDR_IRQ_STATUS: rd_data_reg <= {28'h0, irq_status_reg};
        ADDR_IRQ_MASK: rd_data_reg <= {28'h0, irq_mask_reg};
        ADDR_STATUS: rd_data_reg <= {21'h0, red_mode, 1'b0, yellow_mode,
          failed_reg, expired_reg, buffer_stop_reg};
        ADDR_CTRL: rd_data_reg <= {30'h0, ctrl_reg};
        ADDR_SETTINGS: rd_data_reg <= {buffer_mv_reg, 10'h0, rdy_done_reg, size_large_reg,
          1'b0, limiter_pos};
        default: rd_data_reg <= '0;
      endcase
    end
  end

  assign rd_data = rd_data_reg;
  assign led_green = led_green_reg;
  assign led_yellow = led_yellow_reg;
  assign led_red = led_red_reg;
  assign buffer_stop = buffer_stop_reg;
  assign size_large = size_large_reg;
  assign buffer_mv = buffer_mv_reg;
  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic plain;
  assign plain = ctrl_reg == CTRL_RESET;

  green_ready_a: assert property (plain && failed_reg == 2'b00 && !battery_mode && charged_85[0]
    && !wiring_any && !input_low && rdy_done_reg |=> led_green_reg[0]) else $error("ready led not solid");
  green_fast_a: assert property (plain && failed_reg == 2'b00 && battery_mode
    |=> led_green_reg[0] == $past(fast_on)) else $error("buffering led not fast");
  ready_hold_a: assert property (!rdy_done_reg && plain && !battery_mode && charged_85[1]
    && failed_reg == 2'b00 |=> led_green_reg[1] == $past(slow_on)) else $error("ready shown too early");
  fail_dark_a: assert property (failed_reg[1] && !ctrl_reg[CTRL_LAMP_TEST]
    |=> !led_green_reg[1]) else $error("failed battery led lit");
  red_solid_a: assert property (plain && wiring_any |=> led_red_reg) else $error("fault led not solid");
  expired_hold_a: assert property (discharged_evt |=> expired_reg [*8]) else $error("expiry not held");
  limiter_stop_a: assert property (limit_hit |=> buffer_stop_reg ##1 buffer_stop_reg || !battery_mode)
    else $error("limiter did not stop");
  unlimited_a: assert property (limiter_pos == LIM_POS_NONE && battery_mode && !buffer_stop_reg
    |=> !buffer_stop_reg) else $error("unlimited setting stopped");
  volt_sel_a: assert property (voltage_pos == 2'h3 |=> buffer_mv_reg == VOLT_3_MV)
    else $error("voltage selector wrong");
  irq_level_a: assert property (irq_reg == $past(irq_any) || !$past(rst_n))
    else $error("interrupt level wrong");

endmodule
`default_nettype wire

/* File: core/ups_pkg.sv */
package ups_pkg;
  // register map, byte addresses on the plain port
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_SETTINGS = 8'h10;
  // interrupt status bit positions
  localparam int IRQ_TEST_FAIL = 0;
  localparam int IRQ_EXPIRED = 1;
  localparam int IRQ_WIRING = 2;
  localparam int IRQ_BUFFER = 3;
  localparam int IRQ_W = 4;
  // control bits
  localparam int CTRL_LED_EN = 0;
  localparam int CTRL_LAMP_TEST = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;
  // timing
  localparam int CLK_HZ = 10000000;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam int TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int READY_DELAY_S = 20;
  localparam int EXPIRED_HOLD_MIN = 15;
  localparam int LIM_A_S = 10;
  localparam int LIM_B_S = 30;
  localparam int LIM_C_S = 60;
  localparam int LIM_D_MIN = 3;
  localparam int LIM_E_MIN = 10;
  localparam int MS_W = 20;
  // flash patterns in milliseconds
  localparam int SLOW_PERIOD_MS = 1000;
  localparam int FAST_PERIOD_MS = 250;
  localparam int FLASH_FRAME_MS = 2000;
  localparam int FLASH_ON_MS = 200;
  localparam int PH_W = 11;
  // limiter positions; position zero is the unlimited factory setting
  localparam logic [2:0] LIM_POS_NONE = 3'h0;
  localparam logic [2:0] LIM_POS_A = 3'h1;
  localparam logic [2:0] LIM_POS_B = 3'h2;
  localparam logic [2:0] LIM_POS_C = 3'h3;
  localparam logic [2:0] LIM_POS_D = 3'h4;
  localparam logic [2:0] LIM_POS_E = 3'h5;
  // buffer voltage in millivolts per selector position
  localparam logic [15:0] VOLT_0_MV = 16'h57E4;
  localparam logic [15:0] VOLT_1_MV = 16'h5DC0;
  localparam logic [15:0] VOLT_2_MV = 16'h61A8;
  localparam logic [15:0] VOLT_3_MV = 16'h6590;
  typedef enum logic [2:0] {LED_OFF, LED_SOLID, LED_SLOW, LED_FAST, LED_SINGLE, LED_DOUBLE} led_mode_type;
endpackage

/* File: test/ups_operator_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ups_operator_model
  import ups_pkg::*;
#(
  parameter int MIN_PULSE = 250 * TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic inhibit_req,
  input wire logic sel_size,
  input wire logic [2:0] sel_limit,
  input wire logic [1:0] sel_volt,
  output logic inhibit,
  output logic size_jumper,
  output logic [2:0] limiter_pos,
  output logic [1:0] voltage_pos
);
  int hold_cnt;

  // a short request is stretched so a stop in battery mode is never missed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hold_cnt <= 0;
    end else if (inhibit_req) begin
      hold_cnt <= MIN_PULSE - 1;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // a held request is the static level needed in supply mode
  assign inhibit = inhibit_req || (hold_cnt > 0);
  // switches are plain levels; a missing jumper reads low
  assign size_jumper = sel_size;
  assign limiter_pos = sel_limit;
  assign voltage_pos = sel_volt;
endmodule
`default_nettype wire

/* File: test/ups_status_indicator_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module ups_status_indicator_tb_top
  import ups_pkg::*;
;
  localparam int TK = 2;
  localparam int W = 80;
  localparam int SL = 10 * TK;
  localparam int FA = 4 * TK;
  localparam int FR = 20 * TK;
  localparam int ON = 2 * TK;
  logic clk_sys, rst_n, wr_en, rd_en, battery_mode, input_low, input_over_30v, input_margin_low;
  logic current_over_20a, current_over_25a, center_tap, discharged_evt, unit_over_70c, batt_over_50c;
  logic batt_under_m10c, temp_sensor, inhibit_req, sel_size, inhibit, size_jumper;
  logic led_yellow, led_red, buffer_stop, size_large, irq;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, rv;
  logic [1:0] charged_85, charging, test_fail_evt, sel_volt, voltage_pos, led_green;
  logic [2:0] flt, sel_limit, limiter_pos;
  logic [15:0] buffer_mv;
  logic [15:0] vt [4] = '{VOLT_0_MV, VOLT_1_MV, VOLT_2_MV, VOLT_3_MV};
  int mismatches, total_checks, n;

  ups_status_indicator #(.TICK_DIV(TK), .READY_MS(5), .HOLD_MS(100), .SLOW_MS(10), .FAST_MS(4),
    .FRAME_MS(20), .ON_MS(2)) i_ups_status_indicator (.clk_sys, .rst_n, .addr, .wr_data, .wr_en,
    .rd_en, .rd_data, .charged_85, .charging, .battery_mode, .wiring_fault(flt[0]),
    .battery_fault(flt[1]), .fuse_fault(flt[2]), .input_low, .input_over_30v, .input_margin_low,
    .current_over_20a, .current_over_25a, .test_fail_evt, .center_tap, .discharged_evt, .inhibit,
    .unit_over_70c, .batt_over_50c, .batt_under_m10c, .temp_sensor, .size_jumper, .limiter_pos,
    .voltage_pos, .led_green, .led_yellow, .led_red, .buffer_stop, .size_large, .buffer_mv, .irq);
  ups_operator_model #(.MIN_PULSE(250 * TK)) i_ups_operator_model (.clk_sys, .rst_n, .inhibit_req,
    .sel_size, .sel_limit, .sel_volt, .inhibit, .size_jumper, .limiter_pos, .voltage_pos);

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
    @(posedge clk_sys);
  endtask

  // window spans whole periods of every pattern, so counts do not depend on phase
  task automatic chk_led(input int w, input led_mode_type m);
    int lit, rs, el, er;
    logic p, v;
    lit = 0;
    rs = 0;
    p = 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i <= W; i++) begin
      @(negedge clk_sys);
      v = (w < 2) ? led_green[w] : ((w == 2) ? led_yellow : led_red);
      if (i > 0) begin
        lit += int'(v);
        rs += int'(v & !p);
      end
      p = v;
    end
    case (m)
      LED_SOLID: begin el = W; er = 0; end
      LED_SLOW: begin el = W / 2; er = W / SL; end
      LED_FAST: begin el = W / 2; er = W / FA; end
      LED_SINGLE: begin el = W / FR * ON; er = W / FR; end
      LED_DOUBLE: begin el = 2 * W / FR * ON; er = 2 * W / FR; end
      default: begin el = 0; er = 0; end
    endcase
    `CHK("led_lit", el, lit)
    `CHK("led_rise", er, rs)
    @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst_n, wr_en, rd_en, battery_mode, input_low, input_over_30v, input_margin_low, current_over_20a,
      current_over_25a, center_tap, discharged_evt, unit_over_70c, batt_over_50c, batt_under_m10c,
      temp_sensor, inhibit_req, sel_size, addr, wr_data, charging, test_fail_evt, flt, sel_limit,
      sel_volt} = '0;
    charged_85 = 2'h3;
    mismatches = 0;
    total_checks = 0;
    do_reset();
    @(negedge clk_sys);
    `CHK("rst_out", 5'h0, {led_green, led_yellow, led_red, irq})
    `CHK("rst_mv", VOLT_0_MV, buffer_mv)
    rd(ADDR_SETTINGS, rv);
    `CHK("hold_off", 1'b0, rv[5])
    rd(ADDR_CTRL, rv);
    `CHK("ctrl", 32'h1, rv)
    rd(8'h14, rv);
    `CHK("unmapped", 32'h0, rv)
    wr(8'h20, 32'hF);
    rd(ADDR_IRQ_MASK, rv);
    `CHK("mask", 32'h0, rv)
    repeat (20) @(posedge clk_sys);
    rd(ADDR_SETTINGS, rv);
    `CHK("hold_off", 1'b1, rv[5])
    chk_led(0, LED_SOLID);
    chk_led(1, LED_SOLID);
    input_low <= 1'b1;
    // a charged battery without adequate input falls back to the charging pattern
    chk_led(0, LED_SLOW);
    input_low <= 1'b0;
    charged_85 <= 2'h0;
    charging <= 2'h3;
    chk_led(1, LED_SLOW);
    battery_mode <= 1'b1;
    chk_led(0, LED_FAST);
    battery_mode <= 1'b0;
    charging <= 2'h0;
    charged_85 <= 2'h1;
    chk_led(0, LED_SOLID);
    chk_led(1, LED_OFF);
    current_over_25a <= 1'b1;
    chk_led(2, LED_SOLID);
    current_over_25a <= 1'b0;
    current_over_20a <= 1'b1;
    chk_led(2, LED_OFF);
    battery_mode <= 1'b1;
    chk_led(2, LED_SOLID);
    inhibit_req <= 1'b1;
    chk_led(2, LED_SOLID);
    battery_mode <= 1'b0;
    current_over_20a <= 1'b0;
    chk_led(2, LED_FAST);
    inhibit_req <= 1'b0;
    discharged_evt <= 1'b1;
    @(posedge clk_sys);
    discharged_evt <= 1'b0;
    chk_led(2, LED_DOUBLE);
    repeat (600) @(posedge clk_sys);
    rd(ADDR_STATUS, rv);
    `CHK("expired", 3'(LED_OFF), rv[6:4])
    for (int i = 0; i < 3; i++) begin
      flt <= 3'(1 << i);
      chk_led(3, LED_SOLID);
    end
    flt <= 3'h0;
    input_over_30v <= 1'b1;
    chk_led(3, LED_SINGLE);
    input_over_30v <= 1'b0;
    input_margin_low <= 1'b1;
    chk_led(3, LED_SINGLE);
    unit_over_70c <= 1'b1;
    chk_led(3, LED_DOUBLE);
    flt <= 3'h1;
    chk_led(3, LED_SOLID);
    {flt, unit_over_70c, input_margin_low} <= '0;
    batt_over_50c <= 1'b1;
    chk_led(3, LED_OFF);
    temp_sensor <= 1'b1;
    chk_led(3, LED_DOUBLE);
    batt_over_50c <= 1'b0;
    batt_under_m10c <= 1'b1;
    chk_led(3, LED_DOUBLE);
    sel_size <= 1'b1;
    chk_led(3, LED_OFF);
    batt_under_m10c <= 1'b0;
    for (int v = 0; v < 4; v++) begin
      @(posedge clk_sys);
      sel_volt <= 2'(v);
      repeat (3) @(negedge clk_sys);
      `CHK("mv", vt[v], buffer_mv)
    end
    @(posedge clk_sys);
    sel_limit <= 3'h6;
    rd(ADDR_SETTINGS, rv);
    `CHK("settings", {VOLT_3_MV, 1'b1, 3'h6}, {rv[31:16], rv[4], rv[2:0]})
    `CHK("size", 1'b1, size_large)
    sel_size <= 1'b0;
    sel_limit <= LIM_POS_NONE;
    wr(ADDR_CTRL, 32'h3);
    repeat (3) @(negedge clk_sys);
    `CHK("lamp", 4'hF, {led_green, led_yellow, led_red})
    wr(ADDR_CTRL, 32'h0);
    repeat (3) @(negedge clk_sys);
    `CHK("dark", 4'h0, {led_green, led_yellow, led_red})
    wr(ADDR_CTRL, 32'h1);
    battery_mode <= 1'b1;
    repeat (LIM_A_S * MS_PER_S * TK + 100) @(negedge clk_sys);
    `CHK("unlimited", 1'b0, buffer_stop)
    @(posedge clk_sys);
    battery_mode <= 1'b0;
    sel_limit <= LIM_POS_A;
    repeat (4) @(posedge clk_sys);
    battery_mode <= 1'b1;
    repeat (LIM_A_S * MS_PER_S * TK - 10) @(negedge clk_sys);
    `CHK("early_stop", 1'b0, buffer_stop)
    for (n = 0; n < 40 && buffer_stop !== 1'b1; n++) @(negedge clk_sys);
    `CHK("limit_stop", 1'b1, buffer_stop)
    rd(ADDR_STATUS, rv);
    `CHK("expired", {3'(LED_DOUBLE), 1'b1}, {rv[6:4], rv[1]})
    battery_mode <= 1'b0;
    repeat (3) @(negedge clk_sys);
    `CHK("stop_end", 1'b0, buffer_stop)
    do_reset();
    repeat (20) @(posedge clk_sys);
    charged_85 <= 2'h3;
    center_tap <= 1'b1;
    test_fail_evt <= 2'h2;
    @(posedge clk_sys);
    test_fail_evt <= 2'h0;
    chk_led(2, LED_SLOW);
    chk_led(0, LED_SOLID);
    chk_led(1, LED_OFF);
    `CHK("irq_masked", 1'b0, irq)
    wr(ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(negedge clk_sys);
    `CHK("irq_set", 1'b1, irq)
    wr(ADDR_IRQ_STATUS, 32'h1);
    repeat (3) @(negedge clk_sys);
    `CHK("irq_clear", 1'b0, irq)
    @(posedge clk_sys);
    center_tap <= 1'b0;
    chk_led(0, LED_OFF);
    center_tap <= 1'b1;
    chk_led(0, LED_SOLID);
    test_fail_evt <= 2'h1;
    @(posedge clk_sys);
    test_fail_evt <= 2'h0;
    chk_led(0, LED_OFF);
    wrap_up();
  end
endmodule
`default_nettype wire
